// ---- verilog/spi_event_pkg.sv ----
// Purpose: shared constants and carriers for the serial event mask block
// Assumes: 16-bit registers on a plain strobe port, 10 MHz clock
// Notes:   offsets are word indices on the plain register port
`default_nettype none
package spi_event_pkg;

    // =====================================================
    // register offsets
    localparam logic [3:0] OFF_EVENT_ENABLE_LOW     = 4'h0;
    localparam logic [3:0] OFF_WATERMARK_ENABLE_HIGH = 4'h1;
    localparam logic [3:0] OFF_BAUD_DIVIDER         = 4'h2;
    localparam logic [3:0] OFF_IRQ_STATUS           = 4'h3;
    localparam logic [3:0] OFF_IRQ_MASK             = 4'h4;
    localparam logic [3:0] OFF_LIVE_STATUS          = 4'h5;

    // =====================================================
    // field positions, low register
    localparam int BIT_FRAME_ERROR  = 12;
    localparam int BIT_ACTIVITY     = 11;
    localparam int BIT_UNDERRUN     = 8;
    localparam int BIT_SHIFTER_EMPTY = 7;
    localparam int BIT_OVERFLOW     = 6;
    localparam int BIT_RX_EMPTY     = 5;
    localparam int BIT_TX_EMPTY     = 3;
    localparam int BIT_TX_FULL      = 1;
    localparam int BIT_RX_FULL      = 0;
    localparam logic [15:0] LOW_IMPLEMENTED_MASK = 16'h19eb;

    // field positions, high register
    localparam int BIT_RX_WM_ENABLE = 15;
    localparam int POS_RX_WM_THRESH = 8;
    localparam int BIT_TX_WM_ENABLE = 7;
    localparam int POS_TX_WM_THRESH = 0;
    localparam int THRESH_WIDTH     = 6;

    // interrupt status layout
    localparam int IRQ_BIT_EVENT    = 0;
    localparam int IRQ_BIT_RX_WM    = 1;
    localparam int IRQ_BIT_TX_WM    = 2;
    localparam int IRQ_WIDTH        = 3;

    // reset values
    localparam logic [15:0] RESET_EVENT_ENABLE = 16'h0000;
    localparam logic [15:0] RESET_WATERMARK    = 16'h0000;
    localparam logic [15:0] RESET_BAUD_DIVIDER = 16'h0000;

    // status conditions from the rest of the unit
    typedef struct packed {
        logic frameError;
        logic activity;
        logic underrun;
        logic shifterEmpty;
        logic overflow;
        logic rxEmpty;
        logic txEmpty;
        logic txFull;
        logic rxFull;
    } status_flags_type;

    typedef struct packed {
        logic [15:0]          eventEnable;
        logic [15:0]          watermarkEnable;
        logic [15:0]          baudDivider;
        logic [IRQ_WIDTH-1:0] irqStatus;
        logic [IRQ_WIDTH-1:0] irqMask;
        logic [15:0]          baudCount;
        logic                 serialClock;
        logic                 baudTick;
        logic [15:0]          readData;
        logic                 irq;
        logic                 eventLevel;
        logic                 rxWatermark;
        logic                 txWatermark;
    } state_type;

endpackage : spi_event_pkg

`default_nettype wire

// ---- verilog/spi_event_mask_and_baud.sv ----
// Purpose: interrupt event enables, watermark compare and serial clock divider
// Assumes: status flags and element counts come from logic on clk
// Notes:   one packed state struct, one comb copy, one registered copy
//
// What this block does
// - frame error enable bit 12 gates frame error into the interrupt event
// - activity enable bit 11 gates busy status into the interrupt event
// - underrun enable bit 8 gates transmit underrun into the interrupt event
// - shifter empty enable bit 7 gates idle shifter into interrupt events
// - overflow enable bit 6 gates receive overflow into the interrupt event
// - rx empty enable bit 5 gates empty receive buffer into the event
// - tx empty enable bit 3 gates empty transmit buffer into the event
// - tx full enable bit 1 gates full transmit buffer into the event
// - rx full enable bit 0 gates full receive buffer into the event
// - rx watermark fires when enabled and threshold at most rx count
// - rx threshold is six bits 13-8, compared only when enabled
// - tx watermark fires when enabled and threshold equals tx count
// - thresholds above fifo depth never match
// - threshold bits 2,3,4 exist only for depth at least 8,16,32 respectively
// - unimplemented bits read as zero in both enable registers
// - serial clock equals bus clock over two times divider plus one
// - element counts are six-bit buffer occupancy, enhanced buffer mode
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module spi_event_mask_and_baud
    import spi_event_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [3:0]       regAddr,
    input  wire logic [15:0]      regWriteData,
    input  wire logic             regWrite,
    input  wire logic             regRead,
    output logic      [15:0]      regReadData,
    input  wire status_flags_type statusFlags,
    input  wire logic [5:0]       rxElementCount,
    input  wire logic [5:0]       txElementCount,
    output logic                  eventLevel,
    output logic                  rxWatermark,
    output logic                  txWatermark,
    output logic                  irq,
    output logic                  serialClock,
    output logic                  baudTick
);

    // =====================================================
    // threshold storage shaping
    // bits that do not exist for this depth are tied off in storage
    localparam logic [5:0] THRESH_KEEP = {1'b1,
                                         (FIFO_DEPTH >= 32) ? 1'b1 : 1'b0,
                                         (FIFO_DEPTH >= 16) ? 1'b1 : 1'b0,
                                         (FIFO_DEPTH >= 8) ? 1'b1 : 1'b0,
                                         2'b11};
    localparam logic [6:0] DEPTH_LIMIT = 7'(FIFO_DEPTH);

    // keep only implemented threshold bits
    function automatic logic [5:0] trimThreshold(input logic [5:0] raw);
        trimThreshold = raw & THRESH_KEEP;
    endfunction : trimThreshold

    // a threshold beyond the fifo depth is invalid
    function automatic logic thresholdValid(input logic [5:0] thr);
        thresholdValid = ({1'b0, thr} <= DEPTH_LIMIT);
    endfunction : thresholdValid

    state_type state;
    state_type next_state;

    logic [5:0] rxThreshold;
    logic [5:0] txThreshold;
    logic       anyEvent;
    logic [IRQ_WIDTH-1:0] irqRaise;
    logic       rxMatch;
    logic       txMatch;

    // =====================================================
    // event gating and watermark compare
    always_comb begin
        rxThreshold = state.watermarkEnable[POS_RX_WM_THRESH +: THRESH_WIDTH];
        txThreshold = state.watermarkEnable[POS_TX_WM_THRESH +: THRESH_WIDTH];
        // element counts assumed valid only in enhanced buffer mode
        rxMatch = state.watermarkEnable[BIT_RX_WM_ENABLE]
                  && thresholdValid(rxThreshold)
                  && (rxThreshold <= rxElementCount);
        txMatch = state.watermarkEnable[BIT_TX_WM_ENABLE]
                  && thresholdValid(txThreshold)
                  && (txThreshold == txElementCount);
        anyEvent = (state.eventEnable[BIT_FRAME_ERROR] & statusFlags.frameError)
                 | (state.eventEnable[BIT_ACTIVITY] & statusFlags.activity)
                 | (state.eventEnable[BIT_UNDERRUN] & statusFlags.underrun)
                 | (state.eventEnable[BIT_SHIFTER_EMPTY] & statusFlags.shifterEmpty)
                 | (state.eventEnable[BIT_OVERFLOW] & statusFlags.overflow)
                 | (state.eventEnable[BIT_RX_EMPTY] & statusFlags.rxEmpty)
                 | (state.eventEnable[BIT_TX_EMPTY] & statusFlags.txEmpty)
                 | (state.eventEnable[BIT_TX_FULL] & statusFlags.txFull)
                 | (state.eventEnable[BIT_RX_FULL] & statusFlags.rxFull);
        irqRaise = '0;
        irqRaise[IRQ_BIT_EVENT] = anyEvent;
        irqRaise[IRQ_BIT_RX_WM] = rxMatch;
        irqRaise[IRQ_BIT_TX_WM] = txMatch;
    end

    // =====================================================
    // next state: registers, divider, sticky status
    always_comb begin
        next_state = state;
        next_state.eventLevel  = anyEvent;
        next_state.rxWatermark = rxMatch;
        next_state.txWatermark = txMatch;

        // register writes
        if (regWrite) begin
            case (regAddr)
                OFF_EVENT_ENABLE_LOW: begin
                    next_state.eventEnable = regWriteData & LOW_IMPLEMENTED_MASK;
                end
                OFF_WATERMARK_ENABLE_HIGH: begin
                    next_state.watermarkEnable = {regWriteData[15], 1'b0, trimThreshold(regWriteData[13:8]),
                                                  regWriteData[7], 1'b0, trimThreshold(regWriteData[5:0])};
                end
                OFF_BAUD_DIVIDER: begin
                    next_state.baudDivider = regWriteData;
                end
                OFF_IRQ_MASK: begin
                    next_state.irqMask = regWriteData[IRQ_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end

        // write one to clear, a new event wins over the clear
        if (regWrite && regAddr == OFF_IRQ_STATUS) begin
            next_state.irqStatus = (state.irqStatus & ~regWriteData[IRQ_WIDTH-1:0]) | irqRaise;
        end else begin
            next_state.irqStatus = state.irqStatus | irqRaise;
        end
        next_state.irq = |(next_state.irqStatus & next_state.irqMask);

        // half period of the serial clock lasts divider plus one cycles
        next_state.baudTick = 1'b0;
        if (state.baudCount >= state.baudDivider) begin
            next_state.baudCount   = 16'h0000;
            next_state.serialClock = ~state.serialClock;
            next_state.baudTick    = ~state.serialClock;
        end else begin
            next_state.baudCount = state.baudCount + 16'h0001;
        end

        // read data stands only in the cycle after the strobe
        next_state.readData = 16'h0000;
        if (regRead) begin
            case (regAddr)
                OFF_EVENT_ENABLE_LOW:      next_state.readData = state.eventEnable;
                OFF_WATERMARK_ENABLE_HIGH: next_state.readData = state.watermarkEnable;
                OFF_BAUD_DIVIDER:          next_state.readData = state.baudDivider;
                OFF_IRQ_STATUS:            next_state.readData = 16'(state.irqStatus);
                OFF_IRQ_MASK:              next_state.readData = 16'(state.irqMask);
                OFF_LIVE_STATUS:           next_state.readData = {13'h0000, state.txWatermark,
                                                                  state.rxWatermark, state.eventLevel};
                default:                   next_state.readData = 16'h0000;
            endcase
        end
    end

    // =====================================================
    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            state                 <= '0;
            state.eventEnable     <= RESET_EVENT_ENABLE;
            state.watermarkEnable <= RESET_WATERMARK;
            state.baudDivider     <= RESET_BAUD_DIVIDER;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flip-flops
    assign regReadData = state.readData;
    assign eventLevel  = state.eventLevel;
    assign rxWatermark = state.rxWatermark;
    assign txWatermark = state.txWatermark;
    assign irq         = state.irq;
    assign serialClock = state.serialClock;
    assign baudTick    = state.baudTick;

endmodule : spi_event_mask_and_baud

`default_nettype wire

// ---- test/spi_event_monitor.sv ----
// Purpose: port checker for the event mask and baud block
// Assumes: one clk domain, synchronous rst
// Notes:   shadows software writes to predict the outputs
`timescale 1ns/1ps
`default_nettype none
module spi_event_monitor
    import spi_event_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic [3:0]       regAddr,
    input wire logic [15:0]      regWriteData,
    input wire logic             regWrite,
    input wire logic             regRead,
    input wire logic [15:0]      regReadData,
    input wire status_flags_type statusFlags,
    input wire logic [5:0]       rxElementCount,
    input wire logic [5:0]       txElementCount,
    input wire logic             eventLevel,
    input wire logic             rxWatermark,
    input wire logic             txWatermark,
    input wire logic             irq,
    input wire logic             serialClock,
    input wire logic             baudTick
);
    logic [15:0] low;
    logic [15:0] high;
    logic        maskEv;
    logic [15:0] evVec;
    logic [5:0]  keep;
    // =====================================================
    // shadow state
    // threshold bits absent for small fifos read as zero
    assign keep = {1'b1, FIFO_DEPTH >= 32, FIFO_DEPTH >= 16, FIFO_DEPTH >= 8, 2'b11};
    assign evVec = {3'h0, statusFlags.frameError, statusFlags.activity, 2'h0, statusFlags.underrun,
                    statusFlags.shifterEmpty, statusFlags.overflow, statusFlags.rxEmpty, 1'b0,
                    statusFlags.txEmpty, 1'b0, statusFlags.txFull, statusFlags.rxFull};
    // track what software wrote
    always_ff @(posedge clk) begin
        if (rst) begin
            low    <= 16'h0000;
            high   <= 16'h0000;
            maskEv <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == OFF_EVENT_ENABLE_LOW) low <= regWriteData & LOW_IMPLEMENTED_MASK;
            if (regAddr == OFF_WATERMARK_ENABLE_HIGH) high <= regWriteData & {2'b10, keep, 2'b10, keep};
            if (regAddr == OFF_IRQ_MASK) maskEv <= regWriteData[0];
        end
    end
    // =====================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_read_idle_zero: assert property (!$past(regRead) |-> regReadData == 16'h0000)
        else $error("read data not zero outside read answer");
    a_read_low_value: assert property ($past(regRead && regAddr == OFF_EVENT_ENABLE_LOW)
        |-> regReadData == $past(low)) else $error("low register read wrong");
    a_read_high_value: assert property ($past(regRead && regAddr == OFF_WATERMARK_ENABLE_HIGH)
        |-> regReadData == $past(high)) else $error("high register read wrong");
    a_event_gate: assert property (eventLevel == $past(|(evVec & low)))
        else $error("event level not enabled flags");
    a_rx_watermark: assert property (rxWatermark == $past(high[15] && (high[13:8] <= rxElementCount)
        && (high[13:8] <= FIFO_DEPTH))) else $error("rx watermark wrong");
    a_tx_watermark: assert property (txWatermark == $past(high[7] && (high[5:0] == txElementCount)
        && (high[5:0] <= FIFO_DEPTH))) else $error("tx watermark wrong");
    a_irq_event: assert property (eventLevel && maskEv && $past(maskEv) |-> irq)
        else $error("unmasked event without irq");
    a_tick_single: assert property (baudTick |=> !baudTick)
        else $error("baud tick longer than one cycle");
    a_tick_on_rise: assert property (baudTick == (serialClock && !$past(serialClock)))
        else $error("baud tick not at serial clock rise");
endmodule : spi_event_monitor

bind spi_event_mask_and_baud spi_event_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_spi_event_monitor (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData), .statusFlags(statusFlags),
    .rxElementCount(rxElementCount), .txElementCount(txElementCount), .eventLevel(eventLevel),
    .rxWatermark(rxWatermark), .txWatermark(txWatermark), .irq(irq), .serialClock(serialClock),
    .baudTick(baudTick));
`default_nettype wire

// ---- test/spi_status_source.sv ----
// Purpose: model of the fifo and shifter status feeding the block
// Assumes: enhanced buffer mode
// Notes:   empty and full follow the fill counts, as real fifos do
`timescale 1ns/1ps
`default_nettype none
module spi_status_source
    import spi_event_pkg::*;
(
    input  wire logic [4:0]  eventCause,
    input  wire logic [5:0]  rxFill,
    input  wire logic [5:0]  txFill,
    output status_flags_type statusFlags,
    output logic [5:0]       rxElementCount,
    output logic [5:0]       txElementCount
);
    // empty and full flags derived from occupancy so they can never disagree
    assign statusFlags = {eventCause, rxFill == 6'h00, txFill == 6'h00, txFill == 6'h3f, rxFill == 6'h3f};
    assign rxElementCount = rxFill;
    assign txElementCount = txFill;
endmodule : spi_status_source
`default_nettype wire

// ---- test/spi_event_mask_and_baud_tb.sv ----
// Purpose: register level tests of the event mask and baud block
// Assumes: fifo depth 32, plain strobe register port
// Notes:   expectations come from tables below, not the design
`timescale 1ns/1ps
`default_nettype none
module spi_event_mask_and_baud_tb
    import spi_event_pkg::*;
;
    logic             clk, rst, regWrite, regRead;
    logic [3:0]       regAddr;
    logic [15:0]      regWriteData, regReadData;
    logic [4:0]       eventCause;
    logic [5:0]       rxFill, txFill, rxElementCount, txElementCount;
    status_flags_type statusFlags;
    logic             eventLevel, rxWatermark, txWatermark, irq, serialClock, baudTick, last;
    int               fails, checked, n, rises, ticks;
    int               pos [9] = '{0, 1, 3, 5, 6, 7, 8, 11, 12};
    logic [15:0]      wmCfg [6] = '{16'h8487, 16'h8487, 16'h8487, 16'h0487, 16'ha8a8, 16'h9fa0};
    logic [5:0]       wmRx [6] = '{6'h03, 6'h04, 6'h06, 6'h06, 6'h28, 6'h3f};
    logic [5:0]       wmTx [6] = '{6'h07, 6'h08, 6'h06, 6'h07, 6'h28, 6'h20};
    logic [1:0]       wmExp [6] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h3};
    spi_event_mask_and_baud #(.FIFO_DEPTH(32)) u_spi_event_mask_and_baud (.clk(clk), .rst(rst),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .statusFlags(statusFlags), .rxElementCount(rxElementCount),
        .txElementCount(txElementCount), .eventLevel(eventLevel), .rxWatermark(rxWatermark),
        .txWatermark(txWatermark), .irq(irq), .serialClock(serialClock), .baudTick(baudTick));
    spi_status_source u_spi_status_source (.eventCause(eventCause), .rxFill(rxFill), .txFill(txFill),
        .statusFlags(statusFlags), .rxElementCount(rxElementCount), .txElementCount(txElementCount));
    // =====================================================
    // tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 check(regReadData, exp);
    endtask : rd
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    // =====================================================
    // clock and watchdog, about sixteen times the expected run
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #500000;
        fails++;
        complete_run();
    end
    // =====================================================
    // test sequence
    initial begin
        {rst, regWrite, regRead, regAddr, regWriteData} = {3'b100, 4'h0, 16'h0000};
        {eventCause, rxFill, txFill} = {5'h00, 6'h05, 6'h05};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (n = 0; n < 6; n++) rd(4'(n), 16'h0000);
        wr(4'hf, 16'hffff);
        rd(4'hf, 16'h0000);
        wr(OFF_EVENT_ENABLE_LOW, 16'hffff);
        rd(OFF_EVENT_ENABLE_LOW, 16'h19eb);
        wr(OFF_WATERMARK_ENABLE_HIGH, 16'hffff);
        rd(OFF_WATERMARK_ENABLE_HIGH, 16'hbfbf);
        wr(OFF_WATERMARK_ENABLE_HIGH, 16'h0000);
        wr(OFF_IRQ_MASK, 16'h0001);
        // each flag alone: its own enable passes it, all others do not
        for (n = 0; n < 9; n++) begin
            wr(OFF_EVENT_ENABLE_LOW, 16'h0001 << pos[n]);
            eventCause <= (n > 3) ? 5'(1 << (n - 4)) : 5'h00;
            rxFill <= (n == 3) ? 6'h00 : (n == 0) ? 6'h3f : 6'h05;
            txFill <= (n == 2) ? 6'h00 : (n == 1) ? 6'h3f : 6'h05;
            settle();
            check(eventLevel, 16'h0001);
            check(irq, 16'h0001);
            wr(OFF_EVENT_ENABLE_LOW, ~(16'h0001 << pos[n]));
            settle();
            check(eventLevel, 16'h0000);
            rd(OFF_IRQ_STATUS, 16'h0001);
            wr(OFF_IRQ_STATUS, 16'h0001);
            settle();
            check(irq, 16'h0000);
        end
        // masked raise, then unmask, then clear while still pending
        wr(OFF_IRQ_MASK, 16'h0000);
        {rxFill, txFill} <= {6'h05, 6'h05};
        wr(OFF_EVENT_ENABLE_LOW, 16'h19eb);
        eventCause <= 5'h10;
        settle();
        check(irq, 16'h0000);
        rd(OFF_IRQ_STATUS, 16'h0001);
        rd(OFF_LIVE_STATUS, 16'h0001);
        wr(OFF_IRQ_MASK, 16'h0001);
        wr(OFF_IRQ_STATUS, 16'h0001);
        settle();
        check(irq, 16'h0001);
        wr(OFF_EVENT_ENABLE_LOW, 16'h0000);
        eventCause <= 5'h00;
        // watermark thresholds, disabled compare and invalid values
        for (n = 0; n < 6; n++) begin
            wr(OFF_WATERMARK_ENABLE_HIGH, wmCfg[n]);
            rxFill <= wmRx[n];
            txFill <= wmTx[n];
            settle();
            check({rxWatermark, txWatermark}, wmExp[n]);
        end
        // watermark matches are sticky; a live match survives its own clear
        rd(OFF_IRQ_STATUS, 16'h0007);
        wr(OFF_IRQ_STATUS, 16'h0007);
        rd(OFF_IRQ_STATUS, 16'h0006);
        wr(OFF_IRQ_MASK, 16'h0004);
        settle();
        check(irq, 16'h0001);
        // 24 cycles hold a whole number of periods for each divider
        for (n = 0; n < 3; n++) begin
            wr(OFF_BAUD_DIVIDER, 16'(n));
            repeat (8) @(posedge clk);
            #1 {rises, ticks} = 0;
            repeat (24) begin
                last = serialClock;
                @(posedge clk);
                #1 rises += int'(serialClock === 1'b1 && last === 1'b0);
                ticks += int'(baudTick === 1'b1);
            end
            check(16'(rises), 16'(12 / (n + 1)));
            check(16'(ticks), 16'(12 / (n + 1)));
        end
        complete_run();
    end
endmodule : spi_event_mask_and_baud_tb
`default_nettype wire
